// *** hdl/pic_regs.svh ***
// register offsets, field positions and reset values of the interrupt control
`ifndef PIC_REGS_SVH
`define PIC_REGS_SVH
// printed offsets are not word multiples: these are indices, byte addr = 4*idx
`define PRIO_IDX 16'hFF21
`define ENABLE_IDX 16'hFF23
`define FLAGS_IDX 16'hFF25
`define IRQ_CLEAR_IDX 16'hFF26
`define IRQ_STATUS_IDX 16'hFF27
`define IRQ_ENABLE_IDX 16'hFF28
`define CASCADE_IDX 16'hFF29
`define PRIO_RESET 8'h00
`define ENABLE_RESET 8'h00
`define FLAGS_RESET 8'h00
`define TIMER_PRIO_LSB 2
`define KEYIN_PRIO_LSB 0
`define BIT_TIMER1 7
`define BIT_TIMER0 6
`define BIT_PORT_K1 5
`define BIT_KEYIN_UPPER 4
`define BIT_KEYIN_LOWER 3
`define BIT_SERIAL_ERROR 2
`define BIT_SERIAL_RX 1
`define BIT_SERIAL_TX 0
`define EVT_FLAG_SET 0
`define EVT_REQUEST_RISE 1
`endif

// *** hdl/pic_pkg.sv ***
// types shared by the interrupt control block
package pic_pkg;
  typedef logic [1:0] level_t;
  typedef struct packed {
    logic timer1;
    logic timer0;
    logic port_k1_pair;
    logic keyin_upper;
    logic keyin_lower;
    logic serial_error;
    logic serial_rx;
    logic serial_tx;
  } sources_s;
  typedef struct packed {
    logic valid;
    level_t level;
    logic [2:0] source;
  } request_s;
  typedef enum logic {ADDR_WAIT, DATA_PHASE} bus_state_e;
endpackage : pic_pkg

// *** hdl/peripheral_interrupt_control.sv ***
// peripheral interrupt flags, enables, priorities and request to the cpu
`timescale 1ns/1ps
`default_nettype none
`include "pic_regs.svh"

module peripheral_interrupt_control (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hsel,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire pic_pkg::sources_s cause_event,
  input wire logic timer0_underflow,
  input wire logic timer1_underflow,
  output pic_pkg::request_s cpu_request,
  output logic irq
);

  // ****************************************
  // bus slave
  // ****************************************
  logic wr_pend;
  logic [15:0] wr_idx;
  logic [7:0] prio;
  logic [7:0] enable;
  logic [7:0] flags;
  logic [1:0] irq_status;
  logic [1:0] irq_enable;
  logic cascade;
  logic [7:0] next_flags;
  logic [7:0] wdata;
  logic write_flags;

  function automatic logic [15:0] word_index(input logic [31:0] a);
    word_index = a[17:2];
  endfunction : word_index

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wdata = hwdata[7:0];

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      wr_pend <= 1'b0;
      wr_idx <= 16'h0000;
    end else begin
      wr_pend <= hsel && hready && htrans[1] && hwrite;
      wr_idx <= word_index(haddr);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      hrdata <= 32'h0000_0000;
    end else if (hsel && hready && htrans[1] && !hwrite) begin
      if (word_index(haddr) == `PRIO_IDX) begin
        hrdata <= {24'h000000, 4'h0, prio[3:0]};
      end else if (word_index(haddr) == `ENABLE_IDX) begin
        hrdata <= {24'h000000, enable};
      end else if (word_index(haddr) == `FLAGS_IDX) begin
        hrdata <= {24'h000000, flags};
      end else if (word_index(haddr) == `IRQ_STATUS_IDX) begin
        hrdata <= {30'h00000000, irq_status};
      end else if (word_index(haddr) == `IRQ_ENABLE_IDX) begin
        hrdata <= {30'h00000000, irq_enable};
      end else if (word_index(haddr) == `CASCADE_IDX) begin
        hrdata <= {31'h00000000, cascade};
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end

  // ****************************************
  // priority, enable and mode registers
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      prio <= `PRIO_RESET;
      enable <= `ENABLE_RESET;
      irq_enable <= 2'h0;
      cascade <= 1'b0;
    end else if (wr_pend) begin
      if (wr_idx == `PRIO_IDX) begin
        prio <= {4'h0, wdata[3:0]};
      end else if (wr_idx == `ENABLE_IDX) begin
        enable <= wdata;
      end else if (wr_idx == `IRQ_ENABLE_IDX) begin
        irq_enable <= wdata[1:0];
      end else if (wr_idx == `CASCADE_IDX) begin
        cascade <= wdata[0];
      end
    end
  end

  // ****************************************
  // cause flags
  // ****************************************
  logic [7:0] set_vec;
  always_comb begin
    set_vec = cause_event;
    // cascaded: timer 1 source set only when both timers underflow together, timer 0 source never set
    set_vec[`BIT_TIMER1] = cascade ? timer0_underflow && timer1_underflow
                                   : timer1_underflow;
    set_vec[`BIT_TIMER0] = !cascade && timer0_underflow;
  end

  assign write_flags = wr_pend && (wr_idx == `FLAGS_IDX);

  always_comb begin
    next_flags = flags;
    if (write_flags) begin
      next_flags = flags & ~wdata;
    end
    next_flags = next_flags | set_vec;
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      flags <= `FLAGS_RESET;
    end else begin
      flags <= next_flags;
    end
  end

  // ****************************************
  // request to cpu
  // ****************************************
  function automatic pic_pkg::level_t src_level(input logic [2:0] s,
                                                input logic [7:0] p);
    if (s >= 3'd6) begin
      src_level = p[`TIMER_PRIO_LSB +: 2];
    end else if (s == 3'd5) begin
      src_level = p[`KEYIN_PRIO_LSB +: 2];
    end else begin
      src_level = 2'h3;
    end
  endfunction : src_level

  pic_pkg::request_s next_request;
  logic [7:0] active;
  assign active = flags & enable;

  always_comb begin
    next_request = '0;
    for (int i = 0; i < 8; i++) begin
      if (active[i] && src_level(3'(i), prio) != 2'h0 &&
          src_level(3'(i), prio) >= next_request.level) begin
        next_request.valid = 1'b1;
        next_request.level = src_level(3'(i), prio);
        next_request.source = 3'(i);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      cpu_request <= '0;
    end else begin
      cpu_request <= next_request;
    end
  end

  // ****************************************
  // interrupt status
  // ****************************************
  logic req_prev;
  logic [1:0] next_status;
  always_comb begin
    next_status = irq_status;
    if (wr_pend && wr_idx == `IRQ_CLEAR_IDX) begin
      next_status = irq_status & ~wdata[1:0];
    end
    next_status[`EVT_FLAG_SET] = next_status[`EVT_FLAG_SET] | (|set_vec);
    next_status[`EVT_REQUEST_RISE] = next_status[`EVT_REQUEST_RISE] |
                                     (next_request.valid && !req_prev);
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      irq_status <= 2'h0;
      req_prev <= 1'b0;
    end else begin
      irq_status <= next_status;
      req_prev <= next_request.valid;
    end
  end

  assign irq = |(irq_status & irq_enable);

  // ****************************************
  // checks
  // ****************************************
  property p_flag_set;
    @(posedge clk_sys) disable iff (!rstn)
    cause_event.serial_rx |=> flags[`BIT_SERIAL_RX];
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("serial rx flag not set");

  property p_w1c;
    @(posedge clk_sys) disable iff (!rstn)
    write_flags && wdata[0] && !cause_event.serial_tx |=> !flags[0];
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("flag not cleared by one");

  property p_w0_keep;
    @(posedge clk_sys) disable iff (!rstn)
    write_flags && !wdata[2] && flags[2] |=> flags[2];
  endproperty
  a_w0_keep: assert property (p_w0_keep)
    else $error("flag lost on zero write");

  property p_cascade_t0;
    @(posedge clk_sys) disable iff (!rstn)
    cascade && !flags[6] && !(write_flags && wdata[6]) |=> !flags[6];
  endproperty
  a_cascade_t0: assert property (p_cascade_t0)
    else $error("timer 0 flag set in cascade");

  property p_cascade_t1;
    @(posedge clk_sys) disable iff (!rstn)
    cascade && timer1_underflow && !timer0_underflow && !flags[7] &&
    !cause_event.timer1 |=> !flags[7];
  endproperty
  a_cascade_t1: assert property (p_cascade_t1)
    else $error("timer 1 alone set flag in cascade");

  property p_no_req;
    @(posedge clk_sys) disable iff (!rstn)
    (active == 8'h00) |=> !cpu_request.valid;
  endproperty
  a_no_req: assert property (p_no_req)
    else $error("request without active source");

  property p_level0;
    @(posedge clk_sys) disable iff (!rstn)
    cpu_request.valid |-> cpu_request.level != 2'h0;
  endproperty
  a_level0: assert property (p_level0)
    else $error("level zero requested");

  property p_timer_level;
    @(posedge clk_sys) disable iff (!rstn)
    cpu_request.valid && cpu_request.source == 3'd7 |->
      cpu_request.level == $past(prio[3:2]);
  endproperty
  a_timer_level: assert property (p_timer_level)
    else $error("timer level mismatch");

  property p_key_level;
    @(posedge clk_sys) disable iff (!rstn)
    cpu_request.valid && cpu_request.source == 3'd5 |->
      cpu_request.level == $past(prio[1:0]);
  endproperty
  a_key_level: assert property (p_key_level)
    else $error("key level mismatch");

  property p_enable_gate;
    @(posedge clk_sys) disable iff (!rstn)
    cpu_request.valid |->
      |($past(enable) & (8'h01 << cpu_request.source));
  endproperty
  a_enable_gate: assert property (p_enable_gate)
    else $error("request from disabled source");

  property p_key_enable;
    @(posedge clk_sys) disable iff (!rstn)
    cpu_request.valid && cpu_request.source == 3'd5 |->
      $past(enable[`BIT_PORT_K1]);
  endproperty
  a_key_enable: assert property (p_key_enable)
    else $error("key pair request while disabled");

  property p_reset_zero;
    @(posedge clk_sys)
    !rstn |=> flags == 8'h00 && enable == 8'h00 && prio == 8'h00;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("registers not zero after reset");

endmodule : peripheral_interrupt_control
`default_nettype wire

// *** dv/cpu_irq_model.sv ***
// cpu core interrupt input model facing the interrupt control block
`timescale 1ns/1ps
`default_nettype none
module cpu_irq_model (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire pic_pkg::request_s cpu_request,
  output logic [1:0] taken_level
);
  // ****************************************
  // level of the last request the core saw
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      taken_level <= 2'h0;
    end else if (cpu_request.valid) begin
      taken_level <= cpu_request.level;
    end
  end
endmodule : cpu_irq_model
`default_nettype wire

// *** dv/test_peripheral_interrupt_control.sv ***
// self-checking bench of the peripheral interrupt control
`timescale 1ns/1ps
`default_nettype none
`include "pic_regs.svh"
`define CHK(nm, e, g) begin \
  total_checks++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("unexpected %s exp %0h got %0h", nm, e, g); \
  end \
end
module test_peripheral_interrupt_control;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  wire logic hready;
  logic [31:0] hrdata;
  logic hresp;
  logic [7:0] ev = 8'h0;
  logic t0 = 1'b0;
  logic t1 = 1'b0;
  pic_pkg::request_s req;
  logic irq;
  logic [1:0] taken;
  logic [31:0] rd;
  int n_errors = 0;
  int total_checks = 0;
  always #50 clk_sys = ~clk_sys;
  peripheral_interrupt_control dut (.clk_sys(clk_sys), .rstn(rstn),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hsel(1'b1), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp),
    .cause_event(pic_pkg::sources_s'(ev)), .timer0_underflow(t0),
    .timer1_underflow(t1), .cpu_request(req), .irq(irq));
  cpu_irq_model cpu (.clk_sys(clk_sys), .rstn(rstn), .cpu_request(req),
    .taken_level(taken));
  // ****************************************
  // bus and event tasks
  // ****************************************
  task bus(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
    haddr <= {14'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk_sys); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge clk_sys); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  task rdchk(input logic [15:0] idx, input logic [7:0] e, input string nm);
    bus(1'b0, idx, 8'h00);
    `CHK(nm, {24'h0, e}, rd)
  endtask : rdchk
  task pulse(input logic [7:0] e, input logic a, input logic b);
    ev <= e;
    t0 <= a;
    t1 <= b;
    @(posedge clk_sys);
    ev <= 8'h0;
    t0 <= 1'b0;
    t1 <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask : pulse
  task stop_test();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    rdchk(`PRIO_IDX, 8'h00, "prio");
    rdchk(`ENABLE_IDX, 8'h00, "enable");
    rdchk(`FLAGS_IDX, 8'h00, "flags");
    rdchk(16'h0100, 8'h00, "unmapped");
    bus(1'b1, `ENABLE_IDX, 8'hFF);
    rdchk(`ENABLE_IDX, 8'hFF, "enable new");
    rdchk(`ENABLE_IDX, 8'hFF, "enable");
    bus(1'b1, `PRIO_IDX, 8'hFF);
    rdchk(`PRIO_IDX, 8'h0F, "prio");
    bus(1'b1, `ENABLE_IDX, 8'h00);
    for (int i = 0; i < 8; i++) begin
      pulse(i < 6 ? 8'h01 << i : 8'h00, i == 6, i == 7);
      rdchk(`FLAGS_IDX, 8'hFF >> (7 - i), "flags");
    end
    bus(1'b1, `FLAGS_IDX, 8'h00);
    rdchk(`FLAGS_IDX, 8'hFF, "flags");
    bus(1'b1, `FLAGS_IDX, 8'h02);
    rdchk(`FLAGS_IDX, 8'hFD, "flags");
    bus(1'b1, `FLAGS_IDX, 8'hFF);
    rdchk(`FLAGS_IDX, 8'h00, "flags");
    bus(1'b1, `ENABLE_IDX, 8'h20);
    bus(1'b1, `PRIO_IDX, 8'h02);
    pulse(8'h20, 1'b0, 1'b0);
    `CHK("req", 6'h35, req)
    bus(1'b1, `PRIO_IDX, 8'h00);
    repeat (2) @(posedge clk_sys);
    `CHK("valid", 1'b0, req.valid)
    bus(1'b1, `FLAGS_IDX, 8'hFF);
    bus(1'b1, `ENABLE_IDX, 8'h80);
    pulse(8'h00, 1'b0, 1'b1);
    for (int lv = 0; lv < 4; lv++) begin
      bus(1'b1, `PRIO_IDX, {4'h0, lv[1:0], 2'h0});
      repeat (2) @(posedge clk_sys);
      `CHK("valid", lv != 0, req.valid)
      if (lv != 0) begin
        `CHK("level", lv[1:0], req.level)
      end
    end
    bus(1'b1, `ENABLE_IDX, 8'h00);
    repeat (2) @(posedge clk_sys);
    `CHK("valid", 1'b0, req.valid)
    `CHK("taken", 2'h3, taken)
    bus(1'b1, `FLAGS_IDX, 8'hFF);
    bus(1'b1, `CASCADE_IDX, 8'h01);
    pulse(8'h00, 1'b1, 1'b0);
    pulse(8'h00, 1'b0, 1'b1);
    pulse(8'h00, 1'b1, 1'b1);
    rdchk(`FLAGS_IDX, 8'h80, "flags");
    bus(1'b1, `CASCADE_IDX, 8'h00);
    bus(1'b1, `FLAGS_IDX, 8'hFF);
    bus(1'b1, `IRQ_CLEAR_IDX, 8'h03);
    bus(1'b1, `IRQ_ENABLE_IDX, 8'h00);
    pulse(8'h01, 1'b0, 1'b0);
    `CHK("irq", 1'b0, irq)
    rdchk(`IRQ_STATUS_IDX, 8'h01, "status");
    bus(1'b1, `IRQ_ENABLE_IDX, 8'h01);
    @(posedge clk_sys);
    `CHK("irq", 1'b1, irq)
    bus(1'b1, `IRQ_CLEAR_IDX, 8'h01);
    @(posedge clk_sys);
    `CHK("irq", 1'b0, irq)
    rdchk(`IRQ_CLEAR_IDX, 8'h00, "clear");
    bus(1'b1, `ENABLE_IDX, 8'h01);
    @(posedge clk_sys);
    rdchk(`IRQ_STATUS_IDX, 8'h02, "status");
    `CHK("req", 6'h38, req)
    `CHK("hresp", 1'b0, hresp)
    stop_test();
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_errors++;
    stop_test();
  end
endmodule : test_peripheral_interrupt_control
`default_nettype wire
